// *** twi_slave_pkg.sv ***
// package for the two-wire slave receiver: register map, field positions,
// reset values, status codes, state encodings and the configuration struct.
// assumes byte addresses on a classic wishbone bus with 32-bit data.
package twi_slave_pkg;

   localparam logic [7:0] OFS_ADDR = 8'h00;
   localparam logic [7:0] OFS_CTRL = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;
   localparam logic [7:0] OFS_DATA = 8'h0c;
   localparam logic [7:0] OFS_MODE = 8'h10;

   localparam int CB_OPC = 7;
   localparam int CB_ACK = 6;
   localparam int CB_STA = 5;
   localparam int CB_STO = 4;
   localparam int CB_WCOL = 3;
   localparam int CB_EN = 2;
   localparam int CB_IE = 0;

   localparam logic [7:0] RST_ADDR = 8'h00;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] ST_NONE = 8'hf8;
   localparam logic [7:0] ST_OWN_ACK = 8'h60;
   localparam logic [7:0] ST_OWN_ARB = 8'h68;
   localparam logic [7:0] ST_GC_ACK = 8'h70;
   localparam logic [7:0] ST_GC_ARB = 8'h78;
   localparam logic [7:0] ST_DAT_ACK = 8'h80;
   localparam logic [7:0] ST_DAT_NACK = 8'h88;
   localparam logic [7:0] ST_GCD_ACK = 8'h90;
   localparam logic [7:0] ST_GCD_NACK = 8'h98;
   localparam logic [7:0] PRESC_MASK = 8'hf8;
   localparam logic [6:0] GC_ADDR = 7'h00;
   localparam logic [3:0] BYTE_BITS = 4'h8;

   typedef enum logic [2:0] {
      L_IDLE = 3'b000,
      L_ADDR = 3'b001,
      L_AACK = 3'b010,
      L_HOLD = 3'b011,
      L_DATA = 3'b100,
      L_DACK = 3'b101
   } lstate_e;

   typedef struct packed {
      logic iface_en;
      logic ack_en;
      logic gce;
      logic sleep;
      logic arb;
      logic [6:0] own;
   } cfg_s;

endpackage

// *** twi_slave_rx.sv ***
// two-wire slave receiver with wishbone register access.
// assumes scl/sda are open-drain, resolved outside; link clock free-running.
// Function
// - answer only own 7-bit address or general call
// - general call answered when enable bit set
// - write bit gives receive, read transmit mode
// - own address write sets flag and status
// - prescaler bits of status read zero
// - arbitration lost then addressed enters receive
// - ack_enable cleared gives nack after byte
// - ack_enable zero ignores address, keeps monitoring
// - sleep match still acknowledged, wakes part
// - scl held low until flag cleared
// - data register not updated while asleep
// - own address codes 0x60 and 0x68
// - general call codes 0x70 and 0x78
// - ack_enable at clear decides next ack
//
// Design decisions made here: the Wishbone register port and the address map.
`timescale 1ns/1ns
module twi_slave_rx
   import twi_slave_pkg::*;
(
   input wire logic CLK_SYS_IN, // system clock, 10 MHz
   input wire logic RST_IN, // async reset, active high
   input wire logic LINK_CLK_IN, // link-side sampling clock
   input wire logic WB_CYC_IN, // wishbone cycle
   input wire logic WB_STB_IN, // wishbone strobe
   input wire logic WB_WE_IN, // wishbone write
   input wire logic [7:0] WB_ADR_IN, // byte address
   input wire logic [3:0] WB_SEL_IN, // byte enables
   input wire logic [31:0] WB_DAT_IN, // write data
   output logic [31:0] WB_DAT_OUT, // read data
   output logic WB_ACK_OUT, // wishbone ack
   input wire logic SCL_IN, // bus clock level
   input wire logic SDA_IN, // bus data level
   output logic SCL_OUT, // bus clock drive value
   output logic SCL_OE_OUT, // bus clock pulled low when high
   output logic SDA_OUT, // bus data drive value
   output logic SDA_OE_OUT, // bus data pulled low when high
   input wire logic SLEEP_IN, // non-idle sleep active
   input wire logic ARB_LOST_IN, // master lost arbitration, pulse
   output logic WAKE_OUT // wake request to power control
);

   typedef struct packed {
      logic ev_m;
      logic ev_s;
      logic ev_p;
      logic [1:0] md_m;
      logic [1:0] md_s;
      logic [7:0] own;
      logic ack_en;
      logic sta;
      logic sto;
      logic wcol;
      logic en;
      logic ie;
      logic opc;
      logic clr_tgl;
      logic [7:0] code;
      logic [7:0] data;
      logic arb;
      logic sleep;
      logic ack;
      logic [31:0] dat;
   } sys_s;

   typedef struct packed {
      cfg_s cfg_m;
      cfg_s cfg;
      logic clr_m;
      logic clr_s;
      logic clr_p;
      logic scl_m;
      logic scl_s;
      logic scl_p;
      logic sda_m;
      logic sda_s;
      logic sda_p;
      lstate_e st;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic gc;
      logic ack_plan;
      logic [7:0] code;
      logic [7:0] rxd;
      logic ev_tgl;
      logic rx_mode;
      logic tx_mode;
      logic wake;
      logic scl_oe;
      logic sda_oe;
      logic scl_o;
      logic sda_o;
   } lnk_s;

   sys_s s;
   sys_s next_s;
   lnk_s l;
   lnk_s next_l;
   cfg_s cfg_src;

   // configuration levels handed to the link side, all from flops
   assign cfg_src = '{iface_en: s.en, ack_en: s.ack_en, gce: s.own[0],
                      sleep: s.sleep, arb: s.arb, own: s.own[7:1]};

   // ---------------- system domain ----------------
   logic ev_edge;
   logic req;
   logic wr_ctl;
   logic [7:0] rd_byte;

   assign ev_edge = s.ev_s ^ s.ev_p;
   assign req = WB_CYC_IN && WB_STB_IN && !s.ack;
   assign wr_ctl = req && WB_WE_IN && WB_SEL_IN[0] && (WB_ADR_IN == OFS_CTRL);

   always_comb begin
      next_s = s;
      rd_byte = 8'h00;
      next_s.ev_m = l.ev_tgl;
      next_s.ev_s = s.ev_m;
      next_s.ev_p = s.ev_s;
      next_s.md_m = {l.tx_mode, l.rx_mode};
      next_s.md_s = s.md_m;
      next_s.sleep = SLEEP_IN;
      next_s.ack = req;
      next_s.dat = 32'h0000_0000;
      if (ARB_LOST_IN) begin
         next_s.arb = 1'b1;
      end
      if (req && WB_WE_IN && WB_SEL_IN[0]) begin
         unique case (WB_ADR_IN)
            OFS_ADDR: next_s.own = WB_DAT_IN[7:0];
            OFS_CTRL: begin
               next_s.ack_en = WB_DAT_IN[CB_ACK];
               next_s.sta = WB_DAT_IN[CB_STA];
               next_s.sto = WB_DAT_IN[CB_STO];
               next_s.en = WB_DAT_IN[CB_EN];
               next_s.ie = WB_DAT_IN[CB_IE];
               if (WB_DAT_IN[CB_WCOL]) begin
                  next_s.wcol = 1'b0;
               end
            end
            OFS_DATA: begin
               if (!s.opc) begin
                  next_s.wcol = 1'b1;
               end
            end
            default: begin
            end
         endcase
      end
      // write-one clear releases the stretched clock
      if (wr_ctl && WB_DAT_IN[CB_OPC] && s.opc && !ev_edge) begin
         next_s.opc = 1'b0;
         next_s.clr_tgl = !s.clr_tgl;
         next_s.arb = ARB_LOST_IN; // a loss in the clear cycle still counts
      end
      // a new bus event beats a clear in the same cycle
      if (ev_edge) begin
         next_s.opc = 1'b1;
         next_s.code = l.code;
         if (!s.sleep) begin
            next_s.data = l.rxd;
         end
      end
      if (req && !WB_WE_IN) begin
         unique case (WB_ADR_IN)
            OFS_ADDR: rd_byte = s.own;
            OFS_CTRL: rd_byte = {s.opc, s.ack_en, s.sta, s.sto, s.wcol, s.en, 1'b0, s.ie};
            OFS_STAT: rd_byte = s.code & PRESC_MASK;
            OFS_DATA: rd_byte = s.data;
            OFS_MODE: rd_byte = {6'h00, s.md_s};
            default: rd_byte = 8'h00;
         endcase
         next_s.dat = {24'h00_0000, rd_byte};
      end
   end

   always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
      if (RST_IN) begin
         s <= '{own: RST_ADDR, code: ST_NONE, data: RST_BYTE,
                dat: 32'h0000_0000, default: '0};
      end else begin
         s <= next_s;
      end
   end

   assign WB_ACK_OUT = s.ack;
   assign WB_DAT_OUT = s.dat;

   // ---------------- link domain ----------------
   logic rise;
   logic fall;
   logic start;
   logic stop;
   logic clr_ev;
   logic hit_own;
   logic hit_gc;

   assign rise = l.scl_s && !l.scl_p;
   assign fall = !l.scl_s && l.scl_p;
   assign start = l.scl_s && l.scl_p && l.sda_p && !l.sda_s;
   assign stop = l.scl_s && l.scl_p && !l.sda_p && l.sda_s;
   assign clr_ev = l.clr_s ^ l.clr_p;
   assign hit_own = (l.sh[7:1] == l.cfg.own);
   assign hit_gc = l.cfg.gce && (l.sh[7:1] == GC_ADDR) && !l.sh[0];

   always_comb begin
      next_l = l;
      next_l.cfg_m = cfg_src;
      next_l.cfg = l.cfg_m;
      next_l.clr_m = s.clr_tgl;
      next_l.clr_s = l.clr_m;
      next_l.clr_p = l.clr_s;
      next_l.scl_m = SCL_IN;
      next_l.scl_s = l.scl_m;
      next_l.scl_p = l.scl_s;
      next_l.sda_m = SDA_IN;
      next_l.sda_s = l.sda_m;
      next_l.sda_p = l.sda_s;
      if (!l.cfg.iface_en) begin
         next_l.st = L_IDLE;
         next_l.scl_oe = 1'b0;
         next_l.sda_oe = 1'b0;
         next_l.rx_mode = 1'b0;
         next_l.tx_mode = 1'b0;
         next_l.wake = 1'b0;
      end else if (stop && l.st != L_HOLD) begin
         next_l.st = L_IDLE;
         next_l.sda_oe = 1'b0;
         next_l.rx_mode = 1'b0;
         next_l.tx_mode = 1'b0;
      end else if (start && l.st != L_HOLD) begin
         next_l.st = L_ADDR;
         next_l.cnt = 4'h0;
         next_l.sda_oe = 1'b0;
         next_l.rx_mode = 1'b0;
         next_l.tx_mode = 1'b0;
      end else begin
         unique case (l.st)
            L_IDLE: begin
            end
            L_ADDR: begin
               if (rise) begin
                  next_l.sh = {l.sh[6:0], l.sda_s};
                  next_l.cnt = l.cnt + 4'h1;
               end else if (fall && l.cnt == BYTE_BITS) begin
                  if ((hit_own || hit_gc) && l.cfg.ack_en) begin
                     next_l.sda_oe = 1'b1;
                     next_l.gc = !hit_own;
                     next_l.wake = l.cfg.sleep;
                     next_l.st = L_AACK;
                  end else begin
                     next_l.st = L_IDLE;
                  end
               end
            end
            L_AACK: begin
               if (fall) begin
                  next_l.sda_oe = 1'b0;
                  next_l.cnt = 4'h0;
                  if (l.sh[0]) begin
                     next_l.tx_mode = 1'b1;
                     next_l.st = L_IDLE;
                  end else begin
                     next_l.rx_mode = 1'b1;
                     if (l.gc) begin
                        next_l.code = l.cfg.arb ? ST_GC_ARB : ST_GC_ACK;
                     end else begin
                        next_l.code = l.cfg.arb ? ST_OWN_ARB : ST_OWN_ACK;
                     end
                     next_l.ev_tgl = !l.ev_tgl;
                     next_l.scl_oe = 1'b1;
                     next_l.st = L_HOLD;
                  end
               end
            end
            L_HOLD: begin
               if (clr_ev) begin
                  next_l.scl_oe = 1'b0;
                  next_l.wake = 1'b0;
                  next_l.cnt = 4'h0;
                  if (l.code == ST_DAT_NACK || l.code == ST_GCD_NACK) begin
                     next_l.rx_mode = 1'b0;
                     next_l.st = L_IDLE;
                  end else begin
                     next_l.ack_plan = l.cfg.ack_en;
                     next_l.st = L_DATA;
                  end
               end
            end
            L_DATA: begin
               if (rise) begin
                  next_l.sh = {l.sh[6:0], l.sda_s};
                  next_l.cnt = l.cnt + 4'h1;
               end else if (fall && l.cnt == BYTE_BITS) begin
                  next_l.sda_oe = l.ack_plan;
                  if (!l.cfg.sleep) begin
                     next_l.rxd = l.sh;
                  end
                  if (l.gc) begin
                     next_l.code = l.ack_plan ? ST_GCD_ACK : ST_GCD_NACK;
                  end else begin
                     next_l.code = l.ack_plan ? ST_DAT_ACK : ST_DAT_NACK;
                  end
                  next_l.st = L_DACK;
               end
            end
            L_DACK: begin
               if (fall) begin
                  next_l.sda_oe = 1'b0;
                  next_l.ev_tgl = !l.ev_tgl;
                  next_l.scl_oe = 1'b1;
                  next_l.st = L_HOLD;
               end
            end
            default: begin
               next_l.st = L_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge LINK_CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
         l <= '{st: L_IDLE, code: ST_NONE, scl_m: 1'b1, scl_s: 1'b1, scl_p: 1'b1,
                sda_m: 1'b1, sda_s: 1'b1, sda_p: 1'b1, default: '0};
      end else begin
         l <= next_l;
      end
   end

   assign SCL_OUT = l.scl_o;
   assign SCL_OE_OUT = l.scl_oe;
   assign SDA_OUT = l.sda_o;
   assign SDA_OE_OUT = l.sda_oe;
   assign WAKE_OUT = l.wake;

   // ---------------- checks ----------------
   sequence seq_wr_clr;
      wr_ctl && WB_DAT_IN[CB_OPC] && s.opc && !ev_edge;
   endsequence

   sequence seq_addr_done;
      l.st == L_ADDR && fall && l.cnt == BYTE_BITS;
   endsequence

   AST_EVENT_SETS_FLAG: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      ev_edge |=> s.opc && s.code == $past(l.code))
      else $error("event did not raise op_complete_flag");

   AST_CLEAR_W1C: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      seq_wr_clr |=> !s.opc && s.clr_tgl != $past(s.clr_tgl))
      else $error("write one did not clear op_complete_flag");

   AST_STATUS_PRESCALER: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      (req && !WB_WE_IN && WB_ADR_IN == OFS_STAT) |=> s.ack && s.dat[2:0] == 3'h0)
      else $error("status read shows prescaler bits");

   AST_ACK_ONE_CYCLE: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      req |=> s.ack ##1 !s.ack)
      else $error("wishbone ack not a single cycle");

   AST_ADDR_ACK_CAUSE: assert property (@(posedge LINK_CLK_IN) disable iff (RST_IN)
      seq_addr_done |=> (l.st == L_AACK) == ($past(hit_own || hit_gc) && $past(l.cfg.ack_en)))
      else $error("address acknowledge without match and ack_enable");

   AST_ADDR_ACK_DRIVE: assert property (@(posedge LINK_CLK_IN) disable iff (RST_IN)
      (l.st == L_AACK) |-> l.sda_oe && !l.scl_oe)
      else $error("address acknowledge not driven");

   AST_STRETCH_HOLD: assert property (@(posedge LINK_CLK_IN) disable iff (RST_IN)
      (l.st == L_HOLD && !clr_ev) |=> l.scl_oe && l.st == L_HOLD)
      else $error("clock released before flag cleared");

   AST_ADDR_CODE: assert property (@(posedge LINK_CLK_IN) disable iff (RST_IN)
      (l.st == L_AACK && fall && !l.sh[0]) |=> l.code == ($past(l.gc)
         ? ($past(l.cfg.arb) ? ST_GC_ARB : ST_GC_ACK)
         : ($past(l.cfg.arb) ? ST_OWN_ARB : ST_OWN_ACK)))
      else $error("wrong address status code");

   AST_DATA_NACK: assert property (@(posedge LINK_CLK_IN) disable iff (RST_IN)
      (l.st == L_DATA && fall && l.cnt == BYTE_BITS && !l.ack_plan)
         |=> !l.sda_oe && (l.code == ST_DAT_NACK || l.code == ST_GCD_NACK))
      else $error("byte acknowledged with ack_enable clear");

   AST_WAKE_MATCH: assert property (@(posedge LINK_CLK_IN) disable iff (RST_IN)
      $rose(l.wake) |-> $past(l.st) == L_ADDR && l.st == L_AACK)
      else $error("wake raised without address match");

endmodule // twi_slave_rx

// *** twi_bus_master.sv ***
// behavioural two-wire bus master transmitter with open-drain drives.
// assumes pull-ups on both lines and a 10 MHz pacing clock.
`timescale 1ns/1ns
module twi_bus_master (
   input wire logic clk_in, // pacing clock
   input wire logic scl_in, // resolved clock line
   input wire logic sda_in, // resolved data line
   output logic scl_low_out, // pull clock low
   output logic sda_low_out, // pull data low
   output logic stuck_out // clock held past limit
);
   initial begin
      scl_low_out = 1'b0;
      sda_low_out = 1'b0;
      stuck_out = 1'b0;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   // release clock, wait out stretching for up to 5000 cycles
   task automatic scl_up();
      int i;
      scl_low_out <= 1'b0;
      hold(2);
      for (i = 0; i < 5000 && scl_in !== 1'b1; i++) begin
         hold(1);
      end
      if (scl_in !== 1'b1) begin
         stuck_out <= 1'b1;
      end
      hold(8);
   endtask
   task automatic start();
      sda_low_out <= 1'b1;
      hold(10);
      scl_low_out <= 1'b1;
      hold(10);
   endtask
   task automatic stop();
      sda_low_out <= 1'b1;
      hold(5);
      scl_up();
      sda_low_out <= 1'b0;
      hold(10);
   endtask
   // msb first; data moves only while the clock is low
   task automatic send_byte(input logic [7:0] b, output logic acked);
      int i;
      for (i = 8; i >= 0; i--) begin
         sda_low_out <= (i > 0) ? !b[i-1] : 1'b0;
         hold(5);
         scl_up();
         acked = !sda_in;
         scl_low_out <= 1'b1;
         hold(5);
      end
   endtask
endmodule // twi_bus_master

// *** tb.sv ***
// testbench: wishbone register tests and bus traffic from a master model.
// assumes open-drain lines with pull-ups, resolved here.
`timescale 1ns/1ns
module tb;
   import twi_slave_pkg::*;
   typedef struct packed {
      logic [7:0] sa;
      logic ab;
      logic [7:0] s_a;
      logic [7:0] s_d;
      logic [7:0] s_n;
   } case_s;
   localparam case_s TBL [4] = '{'{8'h54, 1'b0, ST_OWN_ACK, ST_DAT_ACK, ST_DAT_NACK},
      '{8'h54, 1'b1, ST_OWN_ARB, ST_DAT_ACK, ST_DAT_NACK},
      '{8'h00, 1'b0, ST_GC_ACK, ST_GCD_ACK, ST_GCD_NACK},
      '{8'h00, 1'b1, ST_GC_ARB, ST_GCD_ACK, ST_GCD_NACK}};
   logic clk = 1'b0;
   logic lclk = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic sleep = 1'b0;
   logic arb = 1'b0;
   logic [31:0] rdat;
   logic ack, scl_oe, sda_oe, scl_o, sda_o, wake, m_scl, m_sda, stuck, ak;
   logic [31:0] q;
   int fail_count = 0;
   int checks_done = 0;
   int k;
   wire scl = !((scl_oe && !scl_o) || m_scl);
   wire sda = !((sda_oe && !sda_o) || m_sda);
   always #50 clk = !clk;
   initial begin
      #37;
      forever begin
         #62 lclk = 1'b1;
         #63 lclk = 1'b0;
      end
   end
   twi_slave_rx i_dut (.CLK_SYS_IN(clk), .RST_IN(rst), .LINK_CLK_IN(lclk),
      .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel),
      .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .SCL_IN(scl), .SDA_IN(sda),
      .SCL_OUT(scl_o), .SCL_OE_OUT(scl_oe), .SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe),
      .SLEEP_IN(sleep), .ARB_LOST_IN(arb), .WAKE_OUT(wake));
   twi_bus_master master (.clk_in(clk), .scl_in(scl), .sda_in(sda),
      .scl_low_out(m_scl), .sda_low_out(m_sda), .stuck_out(stuck));
   task automatic end_of_test();
      $display("counts: checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // classic single cycle, held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int i;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'h1;
      wdat <= {24'h0, d};
      for (i = 0; i < 20 && ack !== 1'b1; i++) begin
         @(posedge clk);
      end
      if (ack !== 1'b1) begin
         check("wb ack", ack, 32'h1);
         end_of_test();
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
      wb(1'b0, a, 8'h00);
      check(name, q, exp);
   endtask
   task automatic wait_flag();
      int i;
      for (i = 0; i < 100; i++) begin
         wb(1'b0, OFS_CTRL, 8'h00);
         if (q[CB_OPC] === 1'b1) break;
      end
      if (q[CB_OPC] !== 1'b1) begin
         check("flag", q[CB_OPC], 32'h1);
         end_of_test();
      end
   endtask
   task automatic frame(input logic [7:0] b, input logic exp);
      master.start();
      master.send_byte(b, ak);
      check("addr ack", ak, exp);
      if (!exp) master.stop();
   endtask
   // refuse the next byte, then back to idle
   task automatic finish_nack(input logic [7:0] s, input logic [7:0] b);
      wb(1'b1, OFS_CTRL, 8'h84);
      master.send_byte(b, ak);
      check("nack", ak, 32'h0);
      wait_flag();
      rd(OFS_STAT, s, "status nack");
      wb(1'b1, OFS_CTRL, 8'h84);
      master.stop();
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rd(OFS_STAT, ST_NONE, "status");
      rd(OFS_ADDR, RST_ADDR, "addr");
      rd(OFS_CTRL, 32'h0, "ctrl");
      wb(1'b1, 8'h14, 8'hff);
      rd(8'h14, 32'h0, "unmapped");
      wb(1'b1, OFS_ADDR, 8'h55);
      wb(1'b1, OFS_CTRL, 8'h44);
      rd(OFS_ADDR, 32'h55, "addr");
      rd(OFS_CTRL, 32'h44, "ctrl");
      $display("test registers done");
      for (k = 0; k < 4; k++) begin
         if (TBL[k].ab) begin
            @(posedge clk);
            arb <= 1'b1;
            @(posedge clk);
            arb <= 1'b0;
         end
         frame(TBL[k].sa, 1'b1);
         wait_flag();
         rd(OFS_STAT, TBL[k].s_a, "status addr");
         rd(OFS_MODE, 32'h1, "mode rx");
         wb(1'b1, OFS_CTRL, 8'hc4);
         rd(OFS_CTRL, 32'h44, "flag cleared");
         master.send_byte(8'hc3, ak);
         check("data ack", ak, 32'h1);
         wait_flag();
         rd(OFS_STAT, TBL[k].s_d, "status data");
         rd(OFS_DATA, 32'hc3, "data");
         finish_nack(TBL[k].s_n, 8'h3c);
         wb(1'b1, OFS_CTRL, 8'h44);
      end
      $display("test receive table done");
      frame(8'h56, 1'b0);
      rd(OFS_CTRL, 32'h44, "ctrl idle");
      wb(1'b1, OFS_ADDR, 8'h54);
      frame(8'h00, 1'b0);
      wb(1'b1, OFS_CTRL, 8'h04);
      frame(8'h54, 1'b0);
      wb(1'b1, OFS_CTRL, 8'h44);
      frame(8'h54, 1'b1);
      wait_flag();
      finish_nack(ST_DAT_NACK, 8'h3c);
      wb(1'b1, OFS_CTRL, 8'h44);
      frame(8'h55, 1'b1);
      rd(OFS_MODE, 32'h2, "mode tx");
      master.stop();
      $display("test refusals done");
      sleep <= 1'b1;
      frame(8'h54, 1'b1);
      wait_flag();
      check("wake", wake, 32'h1);
      check("scl held", scl_oe, 32'h1);
      check("drive levels", {scl_o, sda_o}, 32'h0);
      repeat (20) @(posedge clk);
      check("scl still held", scl_oe, 32'h1);
      finish_nack(ST_DAT_NACK, 8'h77);
      check("wake released", wake, 32'h0);
      rd(OFS_DATA, 32'h3c, "data asleep");
      sleep <= 1'b0;
      check("stretch limit", stuck, 32'h0);
      $display("test sleep done");
      end_of_test();
   end
endmodule // tb
